//--- fifo_tx_flags_pkg.sv
package fifo_tx_flags_pkg;

   // =====================================================
   // register indices, byte address is four times the index
   localparam logic [4:0] IDX_FLAG_CTRL = 5'h0e;
   localparam logic [4:0] IDX_THRESH    = 5'h0f;
   localparam logic [4:0] IDX_MODE      = 5'h10;
   localparam logic [4:0] IDX_LEVEL     = 5'h11;
   localparam logic [4:0] IDX_STATUS    = 5'h12;

   // =====================================================
   // fields of fifo_tx_flag_control
   localparam int BIT_FILL_METHOD = 7;
   localparam int BIT_FILL        = 6;
   localparam int BIT_TX_DONE     = 5;
   localparam int BIT_LAUNCH      = 4;
   localparam int BIT_LVL_EN      = 3;
   localparam int BIT_LVL_FLAG    = 2;
   localparam int BIT_LOCK        = 1;
   localparam int BIT_LOCK_EN     = 0;
   // field of status register
   localparam int BIT_OVERFLOW    = 0;

   // =====================================================
   // reset values
   localparam logic [7:0] FLAG_CTRL_RST = 8'h01;
   localparam logic [7:0] THRESH_RST    = 8'h00;
   localparam logic [1:0] MODE_RST      = 2'h0;
   localparam logic [6:0] LEVEL_RST     = 7'h0f;

   // =====================================================
   // data_handling_select encodings, 1x is packet mode
   localparam logic [1:0] DM_CONTINUOUS = 2'h0;
   localparam logic [1:0] DM_BUFFERED   = 2'h1;
   localparam int         DM_PACKET_BIT = 1;

   typedef enum logic {FILL_WAIT, FILL_ON} fill_state_e;

endpackage : fifo_tx_flags_pkg

//--- sticky_flag.sv
`timescale 1ns/10ps

// set has priority over clear so no event is lost
module sticky_flag
(
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic set,
   input  wire logic clear,
   output logic      flag
);

   // =====================================================
   // flag storage
   wire next_flag = set | (flag & ~clear);

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         flag <= 1'b0;
      else
         flag <= next_flag;
   end

endmodule : sticky_flag

//--- level_sync.sv
`timescale 1ns/10ps

// two-stage synchroniser, only the second stage is read
module level_sync
(
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic async_in,
   output logic      sync_out
);

   logic meta;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         meta     <= 1'b0;
         sync_out <= 1'b0;
      end
      else
      begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule : level_sync

//--- fifo_tx_irq_status_control.sv
// Functional notes
// RULE_01: auto trigger: sync word starts fifo loading
// RULE_02: manual trigger: loading follows written fill bit
// RULE_03: fill bit only in buffered mode, high while filling
// RULE_04: auto: write one clears, re-arms unless overflow
// RULE_05: manual: write one starts, zero stops filling
// RULE_06: tx finished flag set after last bit
// RULE_07: buffered, launch 0: start on full, nonempty irq
// RULE_08: launch 1: start when nonempty, nonempty irq
// RULE_09: packet, launch 0: start at level, level irq
// RULE_10: bit 3 enables signal-level source, resets zero
// RULE_11: signal-level flag sets above threshold, w1c
// RULE_12: lock flag shows lock, write one clears
// RULE_13: lock enable drives pin, else pin released
// RULE_14: 8-bit threshold, resets zero, signal scale
// RULE_15: mode select: 00 continuous, 01 buffered, 1x packet
// RULE_16: overflow flag, write one clears flag and fifo
// RULE_17: write zero keeps flags, flags stay until cleared
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/10ps

module fifo_tx_irq_status_control
#(
   parameter int COUNT_W = 7
)
(
   input  wire logic               ref_clk,
   input  wire logic               rst,
   // avalon-mm slave
   input  wire logic [6:0]         address,
   input  wire logic               read,
   input  wire logic               write,
   input  wire logic [3:0]         byteenable,
   input  wire logic [31:0]        writedata,
   output logic      [31:0]        readdata,
   output logic                    waitrequest,
   // data handler side
   input  wire logic               sync_detected,
   input  wire logic               fifo_overrun,
   input  wire logic               fifo_full,
   input  wire logic               fifo_empty,
   input  wire logic [COUNT_W-1:0] fifo_count,
   input  wire logic               tx_last_bit_out,
   input  wire logic [7:0]         signal_strength,
   input  wire logic               synth_locked_async,
   output logic                    fifo_fill_enable,
   output logic                    fifo_clear,
   output logic                    tx_start,
   output logic                    irq0,
   output logic                    lock_pin_out,
   output logic                    lock_pin_oe
);

   function automatic logic reg_hit(input logic [6:0] addr, input logic [4:0] idx);
      reg_hit = (addr[6:2] == idx) && (addr[1:0] == 2'h0);
   endfunction : reg_hit

   // =====================================================
   // bus handshake: one wait cycle, access at the low edge
   logic                      fill_method;
   logic                      launch;
   logic                      lvl_en;
   logic                      lock_en;
   logic [7:0]                threshold;
   logic [1:0]                data_mode;
   logic [COUNT_W-1:0]        queue_level_setting;
   fifo_tx_flags_pkg::fill_state_e fill_state;

   wire       access   = (read | write) & waitrequest;
   wire       wr_en    = write & ~waitrequest & byteenable[0];
   wire [7:0] wdata    = writedata[7:0];
   wire       wr_flag  = wr_en & reg_hit(address, fifo_tx_flags_pkg::IDX_FLAG_CTRL);
   wire       wr_thr   = wr_en & reg_hit(address, fifo_tx_flags_pkg::IDX_THRESH);
   wire       wr_mode  = wr_en & reg_hit(address, fifo_tx_flags_pkg::IDX_MODE);
   wire       wr_level = wr_en & reg_hit(address, fifo_tx_flags_pkg::IDX_LEVEL);
   wire       wr_stat  = wr_en & reg_hit(address, fifo_tx_flags_pkg::IDX_STATUS);

   // =====================================================
   // flags
   logic tx_done_flag;
   logic signal_level_flag;
   logic synth_lock_flag;
   logic overflow_flag;
   logic synth_locked;

   level_sync u_lock_sync
   (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .async_in (synth_locked_async),
      .sync_out (synth_locked)
   );

   wire buffered   = (data_mode == fifo_tx_flags_pkg::DM_BUFFERED);
   wire packet     = data_mode[fifo_tx_flags_pkg::DM_PACKET_BIT];
   wire level_hit  = (fifo_count >= queue_level_setting);
   wire above_thr  = lvl_en & (signal_strength > threshold);              // [RULE_11] [RULE_14]
   wire clr_lvl    = wr_flag & wdata[fifo_tx_flags_pkg::BIT_LVL_FLAG];   // [RULE_17]
   wire clr_lock   = wr_flag & wdata[fifo_tx_flags_pkg::BIT_LOCK];
   wire clr_ovf    = wr_stat & wdata[fifo_tx_flags_pkg::BIT_OVERFLOW];   // [RULE_16]
   // tx done is read only: a new launch clears it
   wire next_tx_start;
   wire clr_tx     = next_tx_start & ~tx_start;

   sticky_flag u_tx_done
   (
      .ref_clk (ref_clk),
      .rst     (rst),
      .set     (tx_last_bit_out), // [RULE_06]
      .clear   (clr_tx),
      .flag    (tx_done_flag)
   );

   sticky_flag u_lvl
   (
      .ref_clk (ref_clk),
      .rst     (rst),
      .set     (above_thr),       // [RULE_10] [RULE_11]
      .clear   (clr_lvl),
      .flag    (signal_level_flag)
   );

   // locked level keeps re-setting, so a clear only sticks once lock is lost
   sticky_flag u_lock
   (
      .ref_clk (ref_clk),
      .rst     (rst),
      .set     (synth_locked),    // [RULE_12]
      .clear   (clr_lock),
      .flag    (synth_lock_flag)
   );

   sticky_flag u_ovf
   (
      .ref_clk (ref_clk),
      .rst     (rst),
      .set     (fifo_overrun),    // [RULE_16]
      .clear   (clr_ovf),
      .flag    (overflow_flag)
   );

   // =====================================================
   // fifo fill control
   wire wr_fill_one  = wr_flag & wdata[fifo_tx_flags_pkg::BIT_FILL];
   wire wr_fill_zero = wr_flag & ~wdata[fifo_tx_flags_pkg::BIT_FILL];
   wire fill_on      = (fill_state == fifo_tx_flags_pkg::FILL_ON);
   fifo_tx_flags_pkg::fill_state_e next_fill_state;

   always_comb
   begin
      next_fill_state = fill_state;
      case (fill_state)
         fifo_tx_flags_pkg::FILL_WAIT:
         begin
            if (!fill_method && buffered && sync_detected)
               next_fill_state = fifo_tx_flags_pkg::FILL_ON;      // [RULE_01] [RULE_03]
            else if (fill_method && wr_fill_one)
               next_fill_state = fifo_tx_flags_pkg::FILL_ON;      // [RULE_02] [RULE_05]
         end
         fifo_tx_flags_pkg::FILL_ON:
         begin
            // a sync word in the clearing cycle keeps the fifo filling
            if (!fill_method && wr_fill_one && !overflow_flag && !sync_detected)
               next_fill_state = fifo_tx_flags_pkg::FILL_WAIT;    // [RULE_04]
            else if (fill_method && wr_fill_zero)
               next_fill_state = fifo_tx_flags_pkg::FILL_WAIT;    // [RULE_05]
         end
         default:
            next_fill_state = fifo_tx_flags_pkg::FILL_WAIT;
      endcase
   end

   // =====================================================
   // transmit start and first interrupt line routing
   wire nonempty = ~fifo_empty;
   assign next_tx_start = buffered ? (launch ? nonempty : fifo_full)      // [RULE_07] [RULE_08]
                        : packet ? (launch ? nonempty : level_hit)        // [RULE_09] [RULE_15]
                        : 1'b0;
   wire next_irq0 = packet ? (launch ? nonempty : level_hit)               // [RULE_09]
                  : buffered ? nonempty                                    // [RULE_07] [RULE_08]
                  : 1'b0;

   // =====================================================
   // read data
   wire [7:0] rd_flag  = {fill_method, fill_on, tx_done_flag, launch,
                          lvl_en, signal_level_flag, synth_lock_flag, lock_en};
   wire [7:0] rd_level = {{(8 - COUNT_W){1'b0}}, queue_level_setting};
   wire [7:0] rd_byte  =
      reg_hit(address, fifo_tx_flags_pkg::IDX_FLAG_CTRL) ? rd_flag :
      reg_hit(address, fifo_tx_flags_pkg::IDX_THRESH)    ? threshold :
      reg_hit(address, fifo_tx_flags_pkg::IDX_MODE)      ? {6'h00, data_mode} :
      reg_hit(address, fifo_tx_flags_pkg::IDX_LEVEL)     ? rd_level :
      reg_hit(address, fifo_tx_flags_pkg::IDX_STATUS)    ? {7'h00, overflow_flag} :
      8'h00;

   // =====================================================
   // registers
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         waitrequest <= 1'b1;
         readdata    <= 32'h0000_0000;
      end
      else
      begin
         waitrequest <= ~access;
         if (access && read)
            readdata <= {24'h00_0000, rd_byte};
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         fill_method <= fifo_tx_flags_pkg::FLAG_CTRL_RST[fifo_tx_flags_pkg::BIT_FILL_METHOD];
         launch      <= fifo_tx_flags_pkg::FLAG_CTRL_RST[fifo_tx_flags_pkg::BIT_LAUNCH];
         lvl_en      <= fifo_tx_flags_pkg::FLAG_CTRL_RST[fifo_tx_flags_pkg::BIT_LVL_EN];
         lock_en     <= fifo_tx_flags_pkg::FLAG_CTRL_RST[fifo_tx_flags_pkg::BIT_LOCK_EN];
      end
      else if (wr_flag)
      begin
         fill_method <= wdata[fifo_tx_flags_pkg::BIT_FILL_METHOD];
         launch      <= wdata[fifo_tx_flags_pkg::BIT_LAUNCH];
         lvl_en      <= wdata[fifo_tx_flags_pkg::BIT_LVL_EN];          // [RULE_10]
         lock_en     <= wdata[fifo_tx_flags_pkg::BIT_LOCK_EN];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         threshold           <= fifo_tx_flags_pkg::THRESH_RST;         // [RULE_14]
         data_mode           <= fifo_tx_flags_pkg::MODE_RST;
         queue_level_setting <= COUNT_W'(fifo_tx_flags_pkg::LEVEL_RST);
      end
      else
      begin
         if (wr_thr)
            threshold <= wdata;                                         // [RULE_14]
         if (wr_mode)
            data_mode <= wdata[1:0];                                    // [RULE_15]
         if (wr_level)
            queue_level_setting <= wdata[COUNT_W-1:0];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         fill_state       <= fifo_tx_flags_pkg::FILL_WAIT;
         fifo_fill_enable <= 1'b0;
         fifo_clear       <= 1'b0;
         tx_start         <= 1'b0;
         irq0             <= 1'b0;
         lock_pin_out     <= 1'b0;
         lock_pin_oe      <= 1'b0;
      end
      else
      begin
         fill_state       <= next_fill_state;
         fifo_fill_enable <= buffered & fill_on;                        // [RULE_03]
         fifo_clear       <= clr_ovf;                                   // [RULE_16]
         tx_start         <= next_tx_start;
         irq0             <= next_irq0;
         lock_pin_out     <= synth_lock_flag & lock_en;                 // [RULE_13]
         lock_pin_oe      <= lock_en;                                   // [RULE_13]
      end
   end

   // =====================================================
   // assertions
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   a_auto_fill_start: assert property (       // [RULE_01]
      !fill_method && buffered && sync_detected |=> fill_on ##1 fifo_fill_enable)
      else $error("sync word did not start fifo filling");
   a_auto_rearm: assert property (            // [RULE_04]
      !fill_method && fill_on && wr_fill_one && !overflow_flag && !sync_detected
      |=> !fill_on)
      else $error("write one did not re-arm fill");
   a_manual_fill: assert property (           // [RULE_05]
      fill_method && wr_flag |=> fill_on == $past(wdata[fifo_tx_flags_pkg::BIT_FILL]))
      else $error("manual fill does not follow written bit");
   a_fill_gate: assert property (             // [RULE_03]
      fifo_fill_enable |-> $past(buffered) && $past(fill_on))
      else $error("fill enable outside buffered filling");
   a_tx_done_set: assert property (           // [RULE_06]
      tx_last_bit_out |=> tx_done_flag)
      else $error("tx finished flag not set");
   a_tx_start_full: assert property (         // [RULE_07]
      buffered && !launch |=> tx_start == $past(fifo_full) && irq0 == $past(nonempty))
      else $error("buffered launch wrong");
   a_tx_start_any: assert property (          // [RULE_08]
      launch && data_mode != fifo_tx_flags_pkg::DM_CONTINUOUS && !fifo_empty
      |=> tx_start && irq0)
      else $error("launch on nonempty failed");
   a_tx_start_level: assert property (        // [RULE_09]
      packet && !launch |=> tx_start == $past(level_hit) && irq0 == $past(level_hit))
      else $error("packet level launch wrong");
   a_level_flag: assert property (            // [RULE_11]
      lvl_en && signal_strength > threshold |=> signal_level_flag)
      else $error("signal-level flag not set");
   a_flag_hold: assert property (             // [RULE_17]
      signal_level_flag && !clr_lvl |=> signal_level_flag)
      else $error("signal-level flag dropped without clear");
   a_ovf_clear: assert property (             // [RULE_16]
      clr_ovf && !fifo_overrun |=> !overflow_flag && fifo_clear)
      else $error("overflow clear failed");
   a_lock_pin: assert property (              // [RULE_13]
      !lock_en |=> !lock_pin_oe && !lock_pin_out)
      else $error("lock pin driven while disabled");

   c_auto_cycle:  cover property (fill_on && !fill_method ##1 !fill_on);
   c_manual_fill: cover property (fill_method && wr_fill_one ##1 fill_on);
   c_packet_lvl:  cover property (packet && !launch && level_hit ##1 tx_start);
   c_sig_level:   cover property (signal_level_flag ##1 clr_lvl ##1 !signal_level_flag);

endmodule : fifo_tx_irq_status_control

//--- data_fifo_model.sv
`timescale 1ns/10ps

// =====================================================
// receive/transmit fifo of the data handler, seen from the status block
module data_fifo_model
#(
   parameter int DEPTH = 64
)
(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       tx_push,
   input  wire logic       rx_push,
   input  wire logic       fill_en,
   input  wire logic       clear,
   output logic            full,
   output logic            empty,
   output logic [6:0]      count,
   output logic            overrun
);
   logic add;
   // received bytes only land while filling is enabled
   assign add   = tx_push | (rx_push & fill_en);
   assign full  = (count == 7'(DEPTH));
   assign empty = (count == 7'h00);
   always_ff @(posedge ref_clk)
   begin
      if (rst | clear)
         count <= 7'h00;
      else if (add & !full)
         count <= count + 7'h01;
   end
   // a byte offered while full is lost and reported
   always_ff @(posedge ref_clk)
      overrun <= !rst & add & full;
endmodule : data_fifo_model

//--- test_fifo_tx_irq_status_control.sv
`timescale 1ns/10ps

module test_fifo_tx_irq_status_control;
   logic        ref_clk = 0, rst = 1, read = 0, write = 0, sync_detected = 0;
   logic        tx_last_bit_out = 0, synth_locked_async = 0, tx_push = 0, rx_push = 0;
   logic [6:0]  address = 7'h00, fifo_count;
   logic [31:0] writedata = 32'h0, readdata, q, seed = 32'd5212;
   logic [7:0]  signal_strength = 8'h00, thr, s;
   logic        waitrequest, fifo_overrun, fifo_full, fifo_empty, fill, fifo_clear;
   logic        tx_start, irq0, lock_pin_out, lock_pin_oe;
   logic [3:0]  be = 4'h1;
   int          bad_count = 0, compares = 0, clr_count = 0;

   fifo_tx_irq_status_control dut (.ref_clk(ref_clk), .rst(rst), .address(address),
      .read(read), .write(write), .byteenable(be), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .sync_detected(sync_detected),
      .fifo_overrun(fifo_overrun), .fifo_full(fifo_full), .fifo_empty(fifo_empty),
      .fifo_count(fifo_count), .tx_last_bit_out(tx_last_bit_out),
      .signal_strength(signal_strength), .synth_locked_async(synth_locked_async),
      .fifo_fill_enable(fill), .fifo_clear(fifo_clear), .tx_start(tx_start), .irq0(irq0),
      .lock_pin_out(lock_pin_out), .lock_pin_oe(lock_pin_oe));
   data_fifo_model fifo (.ref_clk(ref_clk), .rst(rst), .tx_push(tx_push), .rx_push(rx_push),
      .fill_en(fill), .clear(fifo_clear), .full(fifo_full), .empty(fifo_empty),
      .count(fifo_count), .overrun(fifo_overrun));

   initial
   begin
      forever #2 ref_clk = ~ref_clk;
   end
   // counts every clear pulse, so a stray or doubled pulse shows up too
   always @(posedge ref_clk) if (fifo_clear === 1'b1) clr_count <= clr_count + 1;

   // =====================================================
   // helpers
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic [31:0] lvl_exp(input logic [7:0] sv, input logic [7:0] tv);
      return (sv > tv) ? 32'h0d : 32'h09;
   endfunction : lvl_exp
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // request held up to the rising edge at which waitrequest is sampled low
   task automatic acc(input logic wr, input logic [6:0] a, input logic [7:0] d);
      int n;
      n = 0;
      address <= a;
      write <= wr;
      read <= !wr;
      writedata <= {24'h0, d};
      @(posedge ref_clk);
      while (waitrequest !== 1'b0 && n < 20)
      begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 20)
      begin
         bad_count++;
         give_verdict();
      end
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge ref_clk);
   endtask : acc
   task automatic rd(input logic [6:0] a, input logic [31:0] e);
      acc(1'b0, a, 8'h00);
      chk(q, e);
   endtask : rd
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      acc(1'b1, a, d);
   endtask : wr
   // outputs: fill, tx_start, irq0, lock_pin_out, lock_pin_oe
   task automatic look(input logic [4:0] e);
      repeat (5) @(posedge ref_clk);
      @(negedge ref_clk);
      chk({27'h0, fill, tx_start, irq0, lock_pin_out, lock_pin_oe}, {27'h0, e});
      @(posedge ref_clk);
   endtask : look
   task automatic pulse_sync();
      sync_detected <= 1'b1;
      @(posedge ref_clk);
      sync_detected <= 1'b0;
      @(posedge ref_clk);
   endtask : pulse_sync
   task automatic push(input logic tx, input int n);
      tx_push <= tx;
      rx_push <= !tx;
      repeat (n) @(posedge ref_clk);
      tx_push <= 1'b0;
      rx_push <= 1'b0;
      @(posedge ref_clk);
   endtask : push

   // =====================================================
   // main sequence
   initial
   begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rd(7'h38, 32'h01);
      rd(7'h3c, 32'h00);
      rd(7'h7c, 32'h00);
      look(5'b00001);
      synth_locked_async <= 1'b1;
      look(5'b00011);
      rd(7'h38, 32'h03);
      wr(7'h38, 8'h00);
      look(5'b00000);
      synth_locked_async <= 1'b0;
      look(5'b00000);
      rd(7'h38, 32'h02);
      wr(7'h38, 8'h03);
      rd(7'h38, 32'h01);
      signal_strength <= 8'hff;
      look(5'b00001);
      rd(7'h38, 32'h01);
      wr(7'h38, 8'h09);
      for (int i = 0; i < 6; i++)
      begin
         signal_strength <= 8'h00;
         thr = xs() & 8'hff;
         wr(7'h3c, thr);
         rd(7'h3c, {24'h0, thr});
         wr(7'h38, 8'h0d);
         s = (i == 0) ? thr : (i == 1) ? thr + 8'h01 : xs() & 8'hff;
         signal_strength <= s;
         look(5'b00001);
         rd(7'h38, lvl_exp(s, thr));
         signal_strength <= 8'h00;
         wr(7'h38, 8'h09);
         rd(7'h38, lvl_exp(s, thr));
      end
      signal_strength <= 8'h00;
      be <= 4'h0;
      wr(7'h3c, ~thr);
      be <= 4'h1;
      rd(7'h3c, {24'h0, thr});
      wr(7'h38, 8'h05);
      wr(7'h40, 8'h01);
      look(5'b00001);
      pulse_sync();
      look(5'b10001);
      rd(7'h38, 32'h41);
      push(1'b0, 2);
      wr(7'h38, 8'h41);
      rd(7'h38, 32'h01);
      look(5'b00101);
      pulse_sync();
      push(1'b0, 70);
      look(5'b11101);
      rd(7'h48, 32'h01);
      wr(7'h38, 8'h41);
      rd(7'h38, 32'h41);
      wr(7'h48, 8'h01);
      look(5'b10001);
      chk(clr_count, 32'h1);
      rd(7'h48, 32'h00);
      wr(7'h38, 8'h41);
      wr(7'h38, 8'h81);
      pulse_sync();
      look(5'b00001);
      wr(7'h38, 8'hc1);
      look(5'b10001);
      wr(7'h38, 8'h81);
      look(5'b00001);
      wr(7'h38, 8'h01);
      push(1'b1, 1);
      look(5'b00101);
      wr(7'h38, 8'h11);
      look(5'b01101);
      wr(7'h40, 8'h02);
      wr(7'h44, 8'h03);
      look(5'b01101);
      wr(7'h38, 8'h01);
      look(5'b00001);
      push(1'b1, 2);
      look(5'b01101);
      wr(7'h40, 8'h00);
      look(5'b00001);
      wr(7'h40, 8'h01);
      push(1'b1, 70);
      look(5'b01101);
      tx_last_bit_out <= 1'b1;
      @(posedge ref_clk);
      tx_last_bit_out <= 1'b0;
      @(posedge ref_clk);
      rd(7'h38, 32'h21);
      wr(7'h38, 8'h01);
      rd(7'h38, 32'h21);
      give_verdict();
   end
endmodule : test_fifo_tx_irq_status_control
